// ---- rtl/dpot_pkg.sv ----
`default_nettype none
package dpot_pkg;

  // ****************************************************************
  // clock and conversion of picosecond floors
  // ****************************************************************
  localparam int SYS_PERIOD_PS = 5000;
  localparam int CK_DIV = 4; // system cycles per memory clock
  localparam int TCK_PS = SYS_PERIOD_PS * CK_DIV;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_CK_HIGH = 2'h2;

  // least times round up to whole memory clocks
  function automatic int ru_nck(input int ps);
    ru_nck = (ps + TCK_PS - 1) / TCK_PS;
  endfunction : ru_nck

  function automatic int max2(input int a, input int b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  // ****************************************************************
  // timing constants, in memory clocks, picoseconds, nanoseconds or refresh intervals
  // ****************************************************************
  localparam int XPDLL_MIN_NCK = 10;
  localparam int XPDLL_MIN_PS = 24000;
  localparam int XP_MIN_NCK = 3;
  localparam int XP_MIN_PS = 6000;
  localparam int CKE_MIN_NCK = 3;
  localparam int CKE_SLOW_PS = 5625; // slower grade, safe for both
  localparam int CKE_FAST_PS = 5000;
  localparam int REFI_NS = 7800;
  localparam int PD_MAX_REFI = 9;
  localparam int RD_PD_EXTRA = 4 + 1;
  localparam int WR_PD_BASE_EIGHT = 4;
  localparam int WR_PD_BASE_CHOP = 2;
  localparam int WRA_PD_EXTRA = 1;
  localparam int ODTH4_NCK = 4;
  localparam int ODTH8_NCK = 6;
  localparam int WLMRD_NCK = 40;
  localparam int WLDQSEN_NCK = 25;

  localparam logic [7:0] XPDLL_CNT = 8'(max2(XPDLL_MIN_NCK, ru_nck(XPDLL_MIN_PS)));
  localparam logic [7:0] XP_CNT = 8'(max2(XP_MIN_NCK, ru_nck(XP_MIN_PS)));
  localparam logic [7:0] CKE_CNT = 8'(max2(CKE_MIN_NCK, ru_nck(CKE_SLOW_PS)));
  // longest time rounds down
  localparam logic [11:0] PD_MAX_CNT = 12'((PD_MAX_REFI * REFI_NS * 1000) / TCK_PS);
  localparam logic [7:0] ODTH4_CNT = 8'(ODTH4_NCK);
  localparam logic [7:0] ODTH8_CNT = 8'(ODTH8_NCK);
  localparam logic [7:0] WLMRD_CNT = 8'(WLMRD_NCK);
  localparam logic [7:0] WLDQSEN_CNT = 8'(WLDQSEN_NCK);

  // ****************************************************************
  // wait counter slots, one per spacing
  // ****************************************************************
  localparam int NW = 8;
  localparam int W_RD = 0;
  localparam int W_WR = 1;
  localparam int W_XP = 2;
  localparam int W_XPDLL = 3;
  localparam int W_CKE = 4;
  localparam int W_ODT = 5;
  localparam int W_WLMRD = 6;
  localparam int W_WLDQS = 7;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_READ = 4'h1, CMD_WRITE = 4'h2, CMD_WRITE_AP = 4'h3,
    CMD_MRS = 4'h4, CMD_WLVL_ON = 4'h5, CMD_WLVL_OFF = 4'h6, CMD_PD_ENTER = 4'h7,
    CMD_PD_EXIT = 4'h8, CMD_ODT_ON = 4'h9, CMD_ODT_OFF = 4'ha, CMD_DQS_ON = 4'hb,
    CMD_DQS_PULSE = 4'hc, CMD_DQS_OFF = 4'hd
  } dpot_cmd_type;

  typedef enum logic [1:0] {
    burst_eight_fixed = 2'h0,
    burst_eight_on_the_fly = 2'h1,
    burst_chop_four_on_the_fly = 2'h2,
    burst_chop_four_fixed = 2'h3
  } dpot_burst_type;

  typedef struct packed {
    dpot_cmd_type cmd;
    dpot_burst_type burst;
  } dpot_req_type;

  typedef struct packed {
    logic [7:0] rl;
    logic [7:0] wl;
    logic [7:0] wr_nck;
    logic dll_frozen;
  } dpot_cfg_type;

  typedef struct packed {
    logic ck;
    logic ck_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic dqs_o;
    logic dqs_oe;
  } dpot_pins_type;

  typedef enum logic [0:0] {
    ST_UP = 1'b0,
    ST_DOWN = 1'b1
  } dpot_st_type;

endpackage : dpot_pkg
`default_nettype wire

// ---- rtl/dpot_ctrl.sv ----
`default_nettype none
module dpot_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // request handshake
  input wire logic req_valid,
  input wire dpot_pkg::dpot_req_type req,
  output logic req_done,
  output logic req_refused,
  // static configuration
  input wire dpot_pkg::dpot_cfg_type cfg,
  // memory pins
  output dpot_pkg::dpot_pins_type pins,
  // status
  output logic powered_down
);
  import dpot_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    dpot_st_type st;
    logic [1:0] phase;
    logic [NW-1:0][7:0] wait_cnt;
    logic [11:0] pd_cnt;
    logic wlvl;
    dpot_pins_type pins;
    logic done;
    logic refused;
  } dpot_state_type;

  dpot_state_type state_reg;
  dpot_state_type state_next;
  logic tick;
  logic lock_ok;
  logic any_ok;
  logic pd_ok;
  logic [NW-1:0] expired;
  logic [7:0] wr_base;
  logic eight;

  // command pins: chip select held low, no-op by default
  function automatic dpot_pins_type put_cmd(input dpot_pins_type p, input logic [3:0] rcw);
    dpot_pins_type q;
    q = p;
    q.cs_n = 1'b0;
    q.ras_n = rcw[2];
    q.cas_n = rcw[1];
    q.we_n = rcw[0];
    put_cmd = q;
  endfunction : put_cmd

  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_READ = 4'h5;
  localparam logic [3:0] PIN_WRITE = 4'h4;
  localparam logic [3:0] PIN_MRS = 4'h0;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.refused = 1'b0;
    state_next.phase = state_reg.phase + 2'h1;
    // one tick per memory clock, so every delay counts real edges
    tick = (state_reg.phase == PHASE_LAST);
    state_next.pins.ck = (state_next.phase >= PHASE_CK_HIGH);
    state_next.pins.ck_n = ~state_next.pins.ck;
    // a slot at one is spent by this very tick, so a wait of n ends exactly n ticks on
    for (int i = 0; i < NW; i++) begin
      expired[i] = (state_reg.wait_cnt[i] <= 8'h01);
    end
    lock_ok = expired[W_XP] && expired[W_XPDLL];
    any_ok = expired[W_XP];
    // entry only once the read, write, clock-enable and exit (XP) spacing counters have run out
    pd_ok = expired[W_RD] && expired[W_WR] && expired[W_CKE] && any_ok;
    eight = (req.burst == burst_eight_fixed) || (req.burst == burst_eight_on_the_fly);
    wr_base = (req.burst == burst_chop_four_fixed) ? 8'(WR_PD_BASE_CHOP)
                                                    : 8'(WR_PD_BASE_EIGHT);
    if (tick) begin
      // commands change on the falling clock and are sampled mid-cycle
      state_next.pins = put_cmd(state_next.pins, PIN_NOP);
      state_next.pins.dqs_o = 1'b0;
      for (int i = 0; i < NW; i++) begin
        if (state_reg.wait_cnt[i] != 8'h00) begin
          state_next.wait_cnt[i] = state_reg.wait_cnt[i] - 8'h01;
        end
      end
      if (state_reg.st == ST_DOWN) begin
        state_next.pd_cnt = state_reg.pd_cnt + 12'h001;
      end
      // the count lags one tick behind the stay, so compare one short to leave at the longest time
      if (state_reg.st == ST_DOWN && state_reg.pd_cnt >= (PD_MAX_CNT - 12'h001) &&
          expired[W_CKE]) begin
        state_next.st = ST_UP;
        state_next.pins.cke = 1'b1;
        state_next.wait_cnt[W_CKE] = CKE_CNT;
        state_next.wait_cnt[W_XP] = XP_CNT;
        if (cfg.dll_frozen) begin
          state_next.wait_cnt[W_XPDLL] = XPDLL_CNT;
        end
        if (req_valid && req.cmd == CMD_PD_EXIT) begin
          state_next.done = 1'b1;
        end
      end else if (req_valid) begin
        state_next.done = 1'b1;
        unique case (req.cmd)
          CMD_NOP: begin
          end
          CMD_READ: begin
            if (state_reg.st == ST_UP && lock_ok) begin
              state_next.pins = put_cmd(state_next.pins, PIN_READ);
              state_next.wait_cnt[W_RD] = 8'(cfg.rl + 8'(RD_PD_EXTRA));
            end else begin
              state_next.done = 1'b0;
            end
          end
          CMD_WRITE, CMD_WRITE_AP: begin
            if (state_reg.st == ST_UP && lock_ok) begin
              state_next.pins = put_cmd(state_next.pins, PIN_WRITE);
              // write recovery added on the base, plus one for auto-precharge
              state_next.wait_cnt[W_WR] = 8'(cfg.wl + wr_base + cfg.wr_nck);
              if (req.cmd == CMD_WRITE_AP) begin
                state_next.wait_cnt[W_WR] = 8'(cfg.wl + wr_base + cfg.wr_nck +
                                              8'(WRA_PD_EXTRA));
              end
              if (state_reg.pins.odt && eight) begin
                state_next.wait_cnt[W_ODT] = ODTH8_CNT;
              end else if (state_reg.pins.odt && state_reg.wait_cnt[W_ODT] < ODTH4_CNT) begin
                state_next.wait_cnt[W_ODT] = ODTH4_CNT;
              end
            end else begin
              state_next.done = 1'b0;
            end
          end
          CMD_MRS, CMD_WLVL_ON, CMD_WLVL_OFF: begin
            if (state_reg.st == ST_UP && any_ok) begin
              state_next.pins = put_cmd(state_next.pins, PIN_MRS);
              if (req.cmd == CMD_WLVL_ON) begin
                state_next.wlvl = 1'b1;
                state_next.wait_cnt[W_WLMRD] = WLMRD_CNT;
                state_next.wait_cnt[W_WLDQS] = WLDQSEN_CNT;
              end else if (req.cmd == CMD_WLVL_OFF) begin
                state_next.wlvl = 1'b0;
                state_next.pins.dqs_oe = 1'b0;
              end
            end else begin
              state_next.done = 1'b0;
            end
          end
          CMD_PD_ENTER: begin
            if (state_reg.st == ST_UP && pd_ok) begin
              state_next.st = ST_DOWN;
              state_next.pins.cke = 1'b0;
              state_next.pd_cnt = 12'h000;
              state_next.wait_cnt[W_CKE] = CKE_CNT;
            end else begin
              state_next.done = 1'b0;
            end
          end
          CMD_PD_EXIT: begin
            // low level held at least tCKE, which is also the least stay
            if (state_reg.st == ST_DOWN && expired[W_CKE]) begin
              state_next.st = ST_UP;
              state_next.pins.cke = 1'b1;
              state_next.wait_cnt[W_CKE] = CKE_CNT;
              state_next.wait_cnt[W_XP] = XP_CNT;
              if (cfg.dll_frozen) begin
                state_next.wait_cnt[W_XPDLL] = XPDLL_CNT;
              end
            end else begin
              state_next.done = 1'b0;
            end
          end
          CMD_ODT_ON: begin
            if (!state_reg.pins.odt) begin
              state_next.pins.odt = 1'b1;
              state_next.wait_cnt[W_ODT] = ODTH4_CNT;
            end
          end
          CMD_ODT_OFF: begin
            if (expired[W_ODT]) begin
              state_next.pins.odt = 1'b0;
            end else begin
              state_next.done = 1'b0;
            end
          end
          CMD_DQS_ON: begin
            if (state_reg.wlvl && expired[W_WLDQS]) begin
              state_next.pins.dqs_oe = 1'b1;
            end else begin
              state_next.done = 1'b0;
            end
          end
          CMD_DQS_PULSE: begin
            if (state_reg.pins.dqs_oe && expired[W_WLMRD]) begin
              state_next.pins.dqs_o = 1'b1;
            end else begin
              state_next.done = 1'b0;
            end
          end
          CMD_DQS_OFF: begin
            state_next.pins.dqs_oe = 1'b0;
          end
          default: begin
            // unknown codes are answered but refused
            state_next.done = 1'b0;
            state_next.refused = 1'b1;
          end
        endcase
      end
      // during power-down the command bus stays at no-op
      if (state_next.st == ST_DOWN) begin
        state_next.pins = put_cmd(state_next.pins, PIN_NOP);
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '{st: ST_UP, phase: 2'h0, wait_cnt: '0, pd_cnt: 12'h000, wlvl: 1'b0,
                     pins: '{ck: 1'b0, ck_n: 1'b1, cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1,
                             cas_n: 1'b1, we_n: 1'b1, odt: 1'b0, dqs_o: 1'b0,
                             dqs_oe: 1'b0},
                     done: 1'b0, refused: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign pins = state_reg.pins;
  assign req_done = state_reg.done;
  assign req_refused = state_reg.refused;
  assign powered_down = (state_reg.st == ST_DOWN);

endmodule : dpot_ctrl
`default_nettype wire

// ---- verif/dpot_ctrl_checker.sv ----
`default_nettype none
module dpot_ctrl_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // request side
  input wire logic req_valid,
  input wire dpot_pkg::dpot_req_type req,
  input wire logic req_done,
  input wire logic req_refused,
  input wire dpot_pkg::dpot_cfg_type cfg,
  // memory side
  input wire dpot_pkg::dpot_pins_type pins,
  input wire logic powered_down
);
  import dpot_pkg::*;
  // ****************
  // ages in system cycles since each event, saturating
  // ****************
  logic [15:0] cke_age, odt_age, rd_age, wr_age, wl_age, wr_need;
  logic cke_q, odt_q, is_cmd, is_wr;
  assign is_cmd = !pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} != 3'h7;
  assign is_wr = req_done && req.cmd inside {CMD_WRITE, CMD_WRITE_AP};
  function automatic logic [15:0] bump(input logic ev, input logic [15:0] a);
    bump = ev ? 16'h1 : (a == 16'hffff ? a : a + 16'h1);
  endfunction : bump
  // restart at the event so a spacing reads straight off the age
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {cke_age, odt_age, rd_age, wr_age, wl_age} <= {5{16'hffff}};
      {cke_q, odt_q} <= 2'h2;
      wr_need <= 16'h0;
    end else begin
      cke_q <= pins.cke;
      odt_q <= pins.odt;
      cke_age <= bump(pins.cke != cke_q, cke_age);
      odt_age <= bump(pins.odt != odt_q, odt_age);
      rd_age <= bump(req_done && req.cmd == CMD_READ, rd_age);
      wr_age <= bump(is_wr, wr_age);
      wl_age <= bump(req_done && req.cmd == CMD_WLVL_ON, wl_age);
      // wait owed by the latest write, held until the next one
      if (is_wr)
        wr_need <= ({8'h0, cfg.wl} + {8'h0, cfg.wr_nck} + (req.cmd == CMD_WRITE_AP ? 16'd1 : 16'd0)
          + (req.burst == burst_chop_four_fixed ? 16'd2 : 16'd4)) * 16'd4;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ck_period: assert property ($rose(pins.ck) |->
    !pins.ck_n ##2 !pins.ck ##2 $rose(pins.ck))
    else $error("memory clock period wrong");
  a_cke_hold: assert property (pins.cke != cke_q |-> cke_age >= 16'd12)
    else $error("clock enable level too short");
  a_pd_quiet: assert property (!pins.cke |-> !is_cmd)
    else $error("command while powered down");
  a_exit_wait: assert property (is_cmd |-> cke_age >= 16'd12)
    else $error("command too soon after exit");
  a_frozen_wait: assert property (is_cmd && pins.ras_n && !pins.cas_n && cfg.dll_frozen |->
    cke_age >= 16'd40)
    else $error("access too soon after frozen exit");
  a_read_pd: assert property ($fell(pins.cke) |->
    rd_age >= ({8'h0, cfg.rl} + 16'd5) * 16'd4)
    else $error("entry too soon after read");
  a_write_pd: assert property ($fell(pins.cke) |-> wr_age >= wr_need)
    else $error("entry too soon after write");
  a_odt_high: assert property (odt_q && !pins.odt |-> odt_age >= 16'd16)
    else $error("termination high too short");
  a_dqs_enable: assert property ($rose(pins.dqs_oe) |-> wl_age >= 16'd100)
    else $error("strobe driven too early");
  a_dqs_first: assert property ($rose(pins.dqs_o) |-> wl_age >= 16'd160)
    else $error("first strobe rise too early");
  cover property ($fell(pins.cke));
  cover property (is_wr);
  cover property ($rose(pins.dqs_o));
endmodule : dpot_ctrl_checker
`default_nettype wire

// ---- verif/dpot_mem_model.sv ----
`default_nettype none
module dpot_mem_model (
  // reset
  input wire logic rst,
  // clock and command pins from the controller
  input wire dpot_pkg::dpot_pins_type pins,
  // count of broken spacings
  output var int n_viol
);
  import dpot_pkg::*;
  // exit wait, max(3, ceil(6 ns / 20 ns)) whole clocks
  localparam int XP_NCK = 3;
  int nck;
  logic cke_q;
  logic is_cmd;
  // only rising memory clock edges count, whatever their spacing
  always @(posedge pins.ck or posedge rst) begin
    if (rst) begin
      n_viol <= 0;
      nck <= 100;
      cke_q <= 1'b1;
    end else begin
      is_cmd = !pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} != 3'h7;
      cke_q <= pins.cke;
      nck <= (pins.cke != cke_q) ? 1 : nck + 1;
      // each clock-enable level stands 3 clocks
      if (pins.cke != cke_q && nck < 3)
        n_viol <= n_viol + 1;
      // inputs closed while down, no-op until the exit wait ends
      else if (is_cmd && (!pins.cke || pins.cke != cke_q || nck < XP_NCK))
        n_viol <= n_viol + 1;
    end
  end
endmodule : dpot_mem_model
`default_nettype wire

// ---- verif/dpot_ctrl_tb.sv ----
`default_nettype none
module dpot_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dpot_pkg::*;
  logic clock = 1'b0, rst = 1'b0, req_valid = 1'b0, last_ref = 1'b0;
  logic req_done, req_refused, powered_down;
  dpot_req_type req = '{CMD_NOP, burst_eight_fixed};
  dpot_cfg_type cfg = '{8'h6, 8'h5, 8'h6, 1'b0};
  dpot_pins_type pins, last_pins;
  int n_viol, n_fail = 0, n_checks = 0, cyc = 0;
  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  dpot_ctrl u_dpot_ctrl (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .req_done(req_done), .req_refused(req_refused), .cfg(cfg), .pins(pins),
    .powered_down(powered_down));
  dpot_mem_model u_dpot_mem_model (.rst(rst), .pins(pins), .n_viol(n_viol));
  // ****************
  // shared tasks
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // t is the cycle of the answer, -1 if none within lim; held past the answer
  task automatic issue(input dpot_cmd_type c, input dpot_burst_type b, input int lim,
                       output int t);
    int k;
    k = 0;
    t = -1;
    req = '{c, b};
    req_valid = 1'b1;
    while (t < 0 && k < lim) begin
      @(posedge clock);
      #1;
      k++;
      if (req_done | req_refused) begin
        t = cyc;
        last_pins = pins;
      end
    end
    last_ref = req_refused;
    if (t >= 0) begin
      @(posedge clock);
      #1;
    end
    req_valid = 1'b0;
    // one edge with valid low, so a following call never lowers and raises it together
    @(posedge clock);
    #1;
  endtask : issue
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // ****************
  // scenarios
  // ****************
  task automatic t_read_pd();
    int a, b;
    issue(CMD_READ, burst_eight_fixed, 50, a);
    check({12'h0, last_pins.cs_n, last_pins.ras_n, last_pins.cas_n, last_pins.we_n}, 16'h5);
    issue(CMD_PD_ENTER, burst_eight_fixed, 200, b);
    check(16'(b - a), 16'((cfg.rl + 5) * 4));
    check({15'h0, last_pins.cke}, 16'h0);
    check({15'h0, powered_down}, 16'h1);
    issue(CMD_READ, burst_eight_fixed, 20, b);
    check(16'(b), 16'hffff);
    issue(CMD_PD_EXIT, burst_eight_fixed, 50, a);
    issue(CMD_READ, burst_eight_fixed, 50, b);
    check(16'(b - a), 16'(3 * 4));
  endtask : t_read_pd
  // every burst kind, plain and auto-precharge
  task automatic t_write_pd();
    int a, b, e, i;
    dpot_burst_type bt;
    for (i = 0; i < 8; i++) begin
      bt = dpot_burst_type'(i[1:0]);
      issue(i[2] ? CMD_WRITE_AP : CMD_WRITE, bt, 50, a);
      issue(CMD_PD_ENTER, bt, 300, b);
      e = (cfg.wl + cfg.wr_nck + i[2] + (bt == burst_chop_four_fixed ? 2 : 4)) * 4;
      check(16'(b - a), 16'(e));
      issue(CMD_PD_EXIT, bt, 50, a);
    end
  endtask : t_write_pd
  // frozen loop exit, then a power-down left to run out
  task automatic t_frozen();
    int a, b;
    cfg.dll_frozen = 1'b1;
    issue(CMD_PD_ENTER, burst_eight_fixed, 50, a);
    issue(CMD_PD_EXIT, burst_eight_fixed, 50, b);
    check(16'(b - a), 16'(3 * 4));
    issue(CMD_WRITE, burst_chop_four_on_the_fly, 80, a);
    check(16'(a - b), 16'(10 * 4));
    cfg.dll_frozen = 1'b0;
    issue(CMD_PD_ENTER, burst_eight_fixed, 300, a);
    while (powered_down === 1'b1 && cyc - a < 15000) begin
      @(posedge clock);
      #1;
    end
    check({15'h0, cyc - a >= 14040 && cyc - a <= 14048}, 16'h1);
  endtask : t_frozen
  task automatic t_odt();
    int a, b;
    issue(CMD_ODT_ON, burst_eight_fixed, 50, a);
    check({15'h0, pins.odt}, 16'h1);
    issue(CMD_ODT_OFF, burst_eight_fixed, 50, b);
    check(16'(b - a), 16'(4 * 4));
    issue(CMD_ODT_ON, burst_eight_fixed, 50, a);
    issue(CMD_WRITE, burst_eight_on_the_fly, 80, a);
    issue(CMD_ODT_OFF, burst_eight_fixed, 50, b);
    check(16'(b - a), 16'(6 * 4));
  endtask : t_odt
  task automatic t_wlvl();
    int a, b;
    issue(CMD_MRS, burst_eight_fixed, 50, a);
    check(16'(last_pins[6:3]), 16'h0); // command bits cs_n down to we_n
    issue(CMD_WLVL_ON, burst_eight_fixed, 80, a);
    issue(CMD_DQS_ON, burst_eight_fixed, 150, b);
    check(16'(b - a), 16'(25 * 4));
    check({15'h0, pins.dqs_oe}, 16'h1);
    issue(CMD_DQS_PULSE, burst_eight_fixed, 150, b);
    check(16'(b - a), 16'(40 * 4));
    check({15'h0, last_pins.dqs_o}, 16'h1);
    issue(CMD_DQS_OFF, burst_eight_fixed, 50, b);
    issue(CMD_WLVL_OFF, burst_eight_fixed, 50, b);
  endtask : t_wlvl
  // unknown code is refused, exit while up is never taken
  task automatic t_refuse();
    int a;
    issue(dpot_cmd_type'(4'he), burst_eight_fixed, 50, a);
    check({15'h0, last_ref}, 16'h1);
    issue(CMD_PD_EXIT, burst_eight_fixed, 20, a);
    check(16'(a), 16'hffff);
  endtask : t_refuse
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b0;
    t_read_pd();
    t_write_pd();
    t_frozen();
    t_odt();
    t_wlvl();
    t_refuse();
    check(16'(n_viol), 16'h0);
    final_report();
  end
  // the forced exit alone is some 70 us, so allow well beyond it
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : dpot_ctrl_tb
bind dpot_ctrl dpot_ctrl_checker u_dpot_ctrl_checker (.clock(clock), .rst(rst),
  .req_valid(req_valid), .req(req), .req_done(req_done), .req_refused(req_refused),
  .cfg(cfg), .pins(pins), .powered_down(powered_down));
`default_nettype wire
